// ### bench/ext_device.sv
`timescale 1ns/1ps

// ************************************************************
// external device: on the bus, ready only after its own access time
// ************************************************************
module ext_device (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // bus side
  input wire logic bus_hold,
  input wire logic [7:0] need,
  output logic ext_ready
);
  logic [7:0] cnt_reg;
  logic flip_reg;

  // count held cycles; off the bus the line toggles, nothing is kept
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 8'h00;
      flip_reg <= 1'b0;
    end else begin
      cnt_reg <= bus_hold ? cnt_reg + 8'h01 : 8'h00;
      flip_reg <= !flip_reg;
    end
  end

  // slow device holds ready low until it has had need cycles
  assign ext_ready = bus_hold ? (cnt_reg >= need) : flip_reg;
endmodule : ext_device

// ### bench/test_wait_gen.sv
`timescale 1ns/1ps

module test_wait_gen;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  wait_gen_pkg::mmr_req_s mmr = '0;
  wait_gen_pkg::access_req_s acc = '0;
  logic [15:0] mmr_rdata;
  logic acc_ready, acc_done, bus_hold, ext_ready, wait_clk_en;
  logic [7:0] need = 8'h00;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 32'h13769bde;
  logic [15:0] got;

  // ************************************************************
  // design, far side and clock
  // ************************************************************
  wait_gen u_dut (.clock(clock), .rst_b(rst_b), .mmr(mmr),
    .mmr_rdata(mmr_rdata), .acc(acc), .acc_ready(acc_ready),
    .acc_done(acc_done), .bus_hold(bus_hold), .ext_ready(ext_ready),
    .wait_clk_en(wait_clk_en));
  ext_device u_dev (.clock(clock), .rst_b(rst_b), .bus_hold(bus_hold),
    .need(need), .ext_ready(ext_ready));
  always #25 clock = !clock;

  // ************************************************************
  // tasks and expectations
  // ************************************************************
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // an idle edge before each strobe keeps back-to-back calls apart
  task automatic wr_reg(logic [7:0] a, logic [15:0] d);
    @(posedge clock);
    #1 mmr.addr = a;
    mmr.wdata = d;
    mmr.wr = 1'b1;
    @(posedge clock);
    #1 mmr.wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    #1 mmr.addr = a;
    mmr.rd = 1'b1;
    @(posedge clock);
    #1 mmr.rd = 1'b0;
    d = mmr_rdata;
  endtask : rd_reg

  // k counts cycles from the taking edge to the done cycle
  task automatic access(wait_gen_pkg::space_e sp, logic [22:0] a,
                        output logic [15:0] k);
    check({14'h0000, bus_hold, acc_ready}, 16'h0001);
    acc.space = sp;
    acc.addr = a;
    acc.req = 1'b1;
    @(posedge clock);
    #1 acc.req = 1'b0;
    check({14'h0000, bus_hold, acc_ready}, 16'h0002);
    k = 16'h0001;
    while (acc_done !== 1'b1 && k < 16'h0040) begin
      @(posedge clock);
      #1 k++;
    end
    @(posedge clock);
    #1 check({14'h0000, bus_hold, acc_ready}, 16'h0001);
  endtask : access

  function automatic logic [15:0] exp_len(logic [15:0] c, logic d,
      wait_gen_pkg::space_e sp, logic [22:0] a, logic [7:0] n);
    logic [2:0] f;
    logic [15:0] w;
    if (sp == wait_gen_pkg::SPACE_IO) f = c[14:12];
    else if (sp == wait_gen_pkg::SPACE_DATA) f = a[15] ? c[11:9] : c[8:6];
    else if (c[15] ? a[22] : a[15]) f = c[5:3];
    else f = c[2:0];
    w = d ? {12'h000, f, 1'b0} : {13'h0000, f};
    return ((w > {8'h00, n}) ? w : {8'h00, n}) + 16'h0001;
  endfunction : exp_len

  // reserved control bits are written as ones to show they stick at zero
  task automatic run_one(logic [15:0] c, logic d, logic [7:0] n);
    wait_gen_pkg::space_e sp;
    logic [22:0] a;
    sp = wait_gen_pkg::space_e'($unsigned($random(seed)) % 3);
    a = 23'($random(seed));
    need = n;
    wr_reg(wait_gen_pkg::CFG_ADDR, c);
    wr_reg(wait_gen_pkg::CTL_ADDR, {15'h7fff, d});
    rd_reg(wait_gen_pkg::CFG_ADDR, got);
    check(got, c);
    rd_reg(wait_gen_pkg::CTL_ADDR, got);
    check(got, {15'h0000, d});
    access(sp, a, got);
    check(got, exp_len(c, d, sp, a, n));
  endtask : run_one

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (20) @(posedge clock);
    #1 rst_b = 1'b1;
    rd_reg(wait_gen_pkg::CFG_ADDR, got);
    check(got, 16'h7fff);
    rd_reg(wait_gen_pkg::CTL_ADDR, got);
    check(got, 16'h0000);
    rd_reg(8'h29, got);
    check(got, 16'h0000);
    access(wait_gen_pkg::SPACE_DATA, 23'h000123, got);
    check(got, 16'h0008);
    run_one(16'hffff, 1'b1, 8'h00);
    check(got, 16'h000f);
    run_one(16'h7fff, 1'b0, 8'h14);
    check(got, 16'h0015);
    run_one(16'h0000, 1'b0, 8'h00);
    check({15'h0000, wait_clk_en}, 16'h0000);
    wr_reg(wait_gen_pkg::CFG_ADDR, 16'h0200);
    @(posedge clock);
    #1 check({15'h0000, wait_clk_en}, 16'h0001);
    // random mix of fields, doubler, spaces and slow devices
    repeat (200) begin
      run_one(16'($random(seed)), 1'($random(seed)),
              8'($unsigned($random(seed)) % 4));
    end
    finish_test();
  end

  // the whole run needs only a small part of this span
  initial begin
    #2000000;
    num_errors++;
    finish_test();
  end
endmodule : test_wait_gen

// ### hw/wait_gen.sv
`timescale 1ns/1ps

// What this block does
// RULE1: internal logic stretches each external cycle by up to fourteen waits.
// RULE2: ready input from external devices extends the cycle beyond that.
// RULE3: config bits 13-0 all zero turns off the wait generator clock enable, even with bit 14 of the I/O field set.
// RULE4: low fifteen config bits hold five three-bit wait counts.
// RULE5: doubler bit scales every base count by one or two.
// RULE6: every range field resets to seven waits.
// RULE7: bits 14-12 set waits for every I/O access.
// RULE8: bits 11-9 set waits for data addresses 8000-ffff.
// RULE9: bits 8-6 set waits for data addresses 0000-7fff.
// RULE10: bits 5-3 set upper program waits, decode chosen by range select.
// RULE11: bits 2-0 set lower program waits, decode chosen by range select.
// RULE12: config bit 15 is the range select, reset to zero.
// RULE13: control register holds doubler in bit 0, other bits read zero.
// RULE14: doubler clear keeps counts, set doubles them; reserved bits ignore writes.
// RULE15: each access decodes its range and holds scaled waits before ending.
module wait_gen (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // memory-mapped register port
  input wire wait_gen_pkg::mmr_req_s mmr,
  output logic [15:0] mmr_rdata,
  // external access from the core
  input wire wait_gen_pkg::access_req_s acc,
  output logic acc_ready,
  output logic acc_done,
  output logic bus_hold,
  // external devices
  input wire logic ext_ready,
  // power
  output logic wait_clk_en
);

  // ************************************************************
  // range decode
  // ************************************************************

  // pick the base count for one access
  function automatic logic [2:0] base_waits(
    input logic [15:0] cfg,
    input wait_gen_pkg::space_e space,
    input logic [wait_gen_pkg::ADDR_W-1:0] addr
  );
    logic upper;
    upper = cfg[wait_gen_pkg::RSEL_BIT] ? addr[wait_gen_pkg::XPAGE_BIT]
                                       : addr[wait_gen_pkg::HALF_BIT]; // RULE12
    case (space)
      wait_gen_pkg::SPACE_IO: begin
        base_waits = cfg[wait_gen_pkg::IO_LSB +: 3]; // RULE7
      end
      wait_gen_pkg::SPACE_DATA: begin
        if (addr[wait_gen_pkg::HALF_BIT]) begin
          base_waits = cfg[wait_gen_pkg::DHI_LSB +: 3]; // RULE8
        end else begin
          base_waits = cfg[wait_gen_pkg::DLO_LSB +: 3]; // RULE9
        end
      end
      default: begin
        if (upper) begin
          base_waits = cfg[wait_gen_pkg::PHI_LSB +: 3]; // RULE10
        end else begin
          base_waits = cfg[wait_gen_pkg::PLO_LSB +: 3]; // RULE11
        end
      end
    endcase
  endfunction : base_waits

  // apply the doubler; widest result is 14
  function automatic logic [3:0] scaled(input logic [2:0] b,
                                        input logic dbl);
    scaled = dbl ? {b, 1'b0} : {1'b0, b}; // RULE5 RULE14
  endfunction : scaled

  // ************************************************************
  // state
  // ************************************************************
  wait_gen_pkg::wsg_state_s state_reg;
  wait_gen_pkg::wsg_state_s state_next;
  logic accept;
  logic [3:0] waits_now;
  logic fields_zero;

  // decode of the access presented this cycle
  assign waits_now = scaled(base_waits(state_reg.cfg, acc.space, acc.addr),
                            state_reg.dbl); // RULE15
  assign fields_zero = state_reg.cfg[13:0] == wait_gen_pkg::FIELDS_ZERO;
  assign accept = acc.req && state_reg.st == wait_gen_pkg::ST_IDLE;

  // handshake outputs from state; done is also gated by ext_ready
  assign acc_ready = state_reg.st == wait_gen_pkg::ST_IDLE;
  assign bus_hold = state_reg.st != wait_gen_pkg::ST_IDLE;
  assign acc_done = state_reg.st == wait_gen_pkg::ST_CHK && ext_ready; // RULE2
  assign mmr_rdata = state_reg.rdata;
  assign wait_clk_en = state_reg.clk_en;

  // next state: register port and wait sequencer
  always_comb begin
    state_next = state_reg;
    // gated when config bits 13-0 are zero, even if bit 14 still gives I/O waits
    state_next.clk_en = !fields_zero; // RULE3
    if (mmr.wr && mmr.addr == wait_gen_pkg::CFG_ADDR) begin
      state_next.cfg = mmr.wdata; // RULE4 RULE12
    end
    if (mmr.wr && mmr.addr == wait_gen_pkg::CTL_ADDR) begin
      // only bit 0 is stored; reserved bits never change
      state_next.dbl = mmr.wdata[wait_gen_pkg::DBL_BIT]; // RULE13 RULE14
    end
    if (mmr.rd) begin
      case (mmr.addr)
        wait_gen_pkg::CFG_ADDR: state_next.rdata = state_reg.cfg;
        wait_gen_pkg::CTL_ADDR: state_next.rdata = {15'h0000,
                                                    state_reg.dbl}; // RULE13
        default: state_next.rdata = 16'h0000;
      endcase
    end
    case (state_reg.st)
      wait_gen_pkg::ST_IDLE: begin
        if (accept && waits_now != 4'h0) begin
          state_next.st = wait_gen_pkg::ST_WAIT; // RULE15
          state_next.cnt = waits_now - 4'h1; // RULE1
        end else if (accept) begin
          state_next.st = wait_gen_pkg::ST_CHK;
        end
      end
      wait_gen_pkg::ST_WAIT: begin
        if (state_reg.cnt == 4'h0) begin
          state_next.st = wait_gen_pkg::ST_CHK;
        end else begin
          state_next.cnt = state_reg.cnt - 4'h1; // RULE1
        end
      end
      wait_gen_pkg::ST_CHK: begin
        // a slow device keeps the cycle open past the software count
        if (ext_ready) begin
          state_next.st = wait_gen_pkg::ST_IDLE; // RULE2
        end
      end
      default: begin
        state_next.st = wait_gen_pkg::ST_IDLE;
      end
    endcase
  end

  // registers; reset gives seven waits in every range
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.st <= wait_gen_pkg::ST_IDLE;
      state_reg.cnt <= 4'h0;
      state_reg.cfg <= wait_gen_pkg::CFG_RESET; // RULE6 RULE12
      state_reg.dbl <= wait_gen_pkg::CTL_RESET[0];
      state_reg.rdata <= 16'h0000;
      state_reg.clk_en <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [3:0] held_reg;
  logic [3:0] seen_reg;
  logic up_reg;

  // helper: waits owed and waits spent for the current access
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      held_reg <= 4'h0;
      seen_reg <= 4'h0;
      up_reg <= 1'b0;
    end else begin
      up_reg <= 1'b1;
      if (accept) begin
        held_reg <= waits_now;
        seen_reg <= 4'h0;
      end else if (state_reg.st == wait_gen_pkg::ST_WAIT) begin
        seen_reg <= seen_reg + 4'h1;
      end
    end
  end

  max_wait_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE1
    state_reg.st == wait_gen_pkg::ST_WAIT |-> state_reg.cnt < 4'he)
    else $error("wait count beyond fourteen");

  wait_len_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE15
    state_reg.st == wait_gen_pkg::ST_CHK &&
    $past(state_reg.st) != wait_gen_pkg::ST_CHK |-> seen_reg == held_reg)
    else $error("waits spent differ from waits owed");

  load_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE5
    accept && waits_now != 4'h0 |=> state_reg.st == wait_gen_pkg::ST_WAIT
    && state_reg.cnt == $past(waits_now) - 4'h1)
    else $error("wait counter loaded wrong");

  ready_hold_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE2
    state_reg.st == wait_gen_pkg::ST_CHK && !ext_ready |=>
    state_reg.st == wait_gen_pkg::ST_CHK && !$past(acc_done))
    else $error("cycle ended without ready");

  gate_off_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE3
    fields_zero |=> !wait_clk_en)
    else $error("wait clock left on with zero fields");

  reset_cfg_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE6
    !up_reg |-> state_reg.cfg == wait_gen_pkg::CFG_RESET && !state_reg.dbl)
    else $error("config not at reset value");

  ctl_read_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE13
    mmr.rd && mmr.addr == wait_gen_pkg::CTL_ADDR |=>
    mmr_rdata == {15'h0000, $past(state_reg.dbl)})
    else $error("control read shows reserved bits");

  io_field_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE7
    accept && acc.space == wait_gen_pkg::SPACE_IO && !state_reg.dbl |->
    waits_now == {1'b0, state_reg.cfg[14:12]})
    else $error("io access used wrong field");

  ext_hi_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE10
    accept && acc.space == wait_gen_pkg::SPACE_PROG
    && state_reg.cfg[wait_gen_pkg::RSEL_BIT]
    && acc.addr[wait_gen_pkg::XPAGE_BIT] && state_reg.dbl |->
    waits_now == {state_reg.cfg[wait_gen_pkg::PHI_LSB +: 3], 1'b0})
    else $error("extended upper program decode wrong");

  // ************************************************************
  // range, register and handshake checks
  // ************************************************************

  // page-half decode while the range select is clear
  prog_hi_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE10
    accept && acc.space == wait_gen_pkg::SPACE_PROG && !state_reg.dbl
    && !state_reg.cfg[wait_gen_pkg::RSEL_BIT]
    && acc.addr[wait_gen_pkg::HALF_BIT] |->
    waits_now == {1'b0, state_reg.cfg[wait_gen_pkg::PHI_LSB +: 3]})
    else $error("upper program decode wrong");

  prog_lo_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE11
    accept && acc.space == wait_gen_pkg::SPACE_PROG && !state_reg.dbl
    && !state_reg.cfg[wait_gen_pkg::RSEL_BIT]
    && !acc.addr[wait_gen_pkg::HALF_BIT] |->
    waits_now == {1'b0, state_reg.cfg[wait_gen_pkg::PLO_LSB +: 3]})
    else $error("lower program decode wrong");

  // data space splits on the half bit whatever the range select says
  data_hi_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE8
    accept && acc.space == wait_gen_pkg::SPACE_DATA && !state_reg.dbl
    && acc.addr[wait_gen_pkg::HALF_BIT] |->
    waits_now == {1'b0, state_reg.cfg[wait_gen_pkg::DHI_LSB +: 3]})
    else $error("upper data decode wrong");

  data_lo_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE9
    accept && acc.space == wait_gen_pkg::SPACE_DATA && !state_reg.dbl
    && !acc.addr[wait_gen_pkg::HALF_BIT] |->
    waits_now == {1'b0, state_reg.cfg[wait_gen_pkg::DLO_LSB +: 3]})
    else $error("lower data decode wrong");

  // doubled count keeps the field in the upper three bits
  dbl_io_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE14
    accept && acc.space == wait_gen_pkg::SPACE_IO && state_reg.dbl |->
    waits_now == {state_reg.cfg[wait_gen_pkg::IO_LSB +: 3], 1'b0})
    else $error("doubled io count wrong");

  // writes land whole in config, only bit 0 in control
  cfg_write_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE4
    mmr.wr && mmr.addr == wait_gen_pkg::CFG_ADDR |=>
    state_reg.cfg == $past(mmr.wdata))
    else $error("config write lost");

  ctl_write_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE14
    mmr.wr && mmr.addr == wait_gen_pkg::CTL_ADDR |=>
    state_reg.dbl == $past(mmr.wdata[wait_gen_pkg::DBL_BIT]))
    else $error("doubler write lost");

  cfg_read_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE12
    mmr.rd && mmr.addr == wait_gen_pkg::CFG_ADDR |=>
    mmr_rdata == $past(state_reg.cfg))
    else $error("config read wrong");

  // the cycle ends once and hands the bus back
  done_idle_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE15
    acc_done |=> acc_ready && !bus_hold)
    else $error("bus still held after done");

  // a slow device keeps the bus held, never released early
  stall_hold_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE2
    state_reg.st == wait_gen_pkg::ST_CHK && !ext_ready |=> bus_hold)
    else $error("bus released while device not ready");

  clk_on_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE3
    !fields_zero |=> wait_clk_en)
    else $error("wait clock left off with a nonzero field");

  // main scenarios: zero wait, longest wait, stall, doubling, wide decode
  zero_cv: cover property (@(posedge clock) disable iff (!rst_b)
    accept && waits_now == 4'h0 ##1 acc_done);
  max_cv: cover property (@(posedge clock) disable iff (!rst_b)
    accept && waits_now == wait_gen_pkg::MAX_WAITS);
  stall_cv: cover property (@(posedge clock) disable iff (!rst_b)
    state_reg.st == wait_gen_pkg::ST_CHK && !ext_ready [*3] ##1 acc_done);
  dbl_cv: cover property (@(posedge clock) disable iff (!rst_b)
    accept && state_reg.dbl && waits_now != 4'h0);
  sel_cv: cover property (@(posedge clock) disable iff (!rst_b)
    accept && acc.space == wait_gen_pkg::SPACE_PROG
    && state_reg.cfg[wait_gen_pkg::RSEL_BIT]);

endmodule : wait_gen

// ### hw/wait_gen_pkg.sv
package wait_gen_pkg;

  // ************************************************************
  // register map and reset values
  // ************************************************************
  localparam logic [7:0] CFG_ADDR = 8'h28;
  localparam logic [7:0] CTL_ADDR = 8'h2b;
  localparam logic [15:0] CFG_RESET = 16'h7fff;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int FIELD_W = 3;
  localparam int CNT_W = 4;
  localparam int IO_LSB = 12;
  localparam int DHI_LSB = 9;
  localparam int DLO_LSB = 6;
  localparam int PHI_LSB = 3;
  localparam int PLO_LSB = 0;
  localparam int RSEL_BIT = 15;
  localparam int DBL_BIT = 0;
  localparam int ADDR_W = 23;
  localparam int XPAGE_BIT = 22;
  localparam int HALF_BIT = 15;
  localparam logic [13:0] FIELDS_ZERO = 14'h0000;
  localparam logic [CNT_W-1:0] MAX_WAITS = 4'he;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    SPACE_PROG = 2'h0,
    SPACE_DATA = 2'h1,
    SPACE_IO = 2'h2
  } space_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_CHK = 2'h3
  } wait_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } mmr_req_s;

  typedef struct packed {
    logic req;
    space_e space;
    logic [ADDR_W-1:0] addr;
  } access_req_s;

  typedef struct packed {
    wait_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [15:0] cfg;
    logic dbl;
    logic [15:0] rdata;
    logic clk_en;
  } wsg_state_s;

endpackage : wait_gen_pkg
